// *** rtl/eelc_consts.vh ***
// register map, reset values and field layout of the edge event line controller
`ifndef EELC_CONSTS_VH
`define EELC_CONSTS_VH
// ==========================================================================
// register offsets
`define EELC_OFF_IMASK 12'h000
`define EELC_OFF_EMASK 12'h004
`define EELC_OFF_RISE 12'h008
`define EELC_OFF_FALL 12'h00c
`define EELC_OFF_SWTRIG 12'h010
`define EELC_OFF_PEND 12'h014
`define EELC_OFF_SEL0 12'h018
`define EELC_OFF_SEL1 12'h01c
`define EELC_OFF_SEL2 12'h020
`define EELC_OFF_SEL3 12'h024
`define EELC_OFF_STAT 12'h028
`define EELC_OFF_SMASK 12'h02c
// ==========================================================================
// reset values
`define EELC_RST_LINES 23'h000000
`define EELC_RST_SEL 7'h00
`define EELC_RST_STAT 2'h0
// ==========================================================================
// field layout
`define EELC_SEL_FIELD 8
`define EELC_SEL_PER_REG 4
`define EELC_STAT_NEW 0
`define EELC_STAT_OVR 1
`endif

// *** rtl/eelc_edge_catch.v ***
// asynchronous edge catcher with toggle crossing into the bus clock
`timescale 1ns/1ps
module eelc_edge_catch (
	input wire pclk,
	input wire presetn,
	input wire line,
	output wire rise_evt,
	output wire fall_evt
);
	// ==========================================================================
	// toggles clocked by the line itself, so narrow pulses are kept
	reg rise_tog;
	reg fall_tog;
	reg [2:0] rise_sync;
	reg [2:0] fall_sync;

	always @(posedge line or negedge presetn) begin
		if (!presetn)
			rise_tog <= 1'h0;
		else
			rise_tog <= ~rise_tog; // R5
	end

	always @(negedge line or negedge presetn) begin
		if (!presetn)
			fall_tog <= 1'h0;
		else
			fall_tog <= ~fall_tog; // R5
	end

	// ==========================================================================
	// two-stage synchronisers, third stage for change detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_sync <= 3'h0;
			fall_sync <= 3'h0;
		end else begin
			rise_sync <= {rise_sync[1:0], rise_tog};
			fall_sync <= {fall_sync[1:0], fall_tog};
		end
	end

	assign rise_evt = rise_sync[2] ^ rise_sync[1];
	assign fall_evt = fall_sync[2] ^ fall_sync[1];
endmodule // eelc_edge_catch

// *** rtl/eelc_top.v ***
// edge event line controller: apb registers, line routing, pending logic
//
// Functional notes
// R1: 23 edge lines, each able to raise an interrupt or an event request.
// R2: per line, software picks rising, falling or both edges.
// R3: per line mask; a masked line raises no request, others unaffected.
// R4: readable per-line pending register of outstanding interrupt requests.
// R5: pulses shorter than one bus clock period are still caught.
// R6: 81 pins route onto lines 0 to 15, one chosen pin per line.
// R7: pending stays until written one; interrupt follows unmasked pending flags (irq_req does; irq follows stat & smask, cleared by reading status).
`timescale 1ns/1ps
`include "eelc_consts.vh"
module eelc_top #(
	parameter NLINES = 23,
	parameter NPINS = 81,
	parameter NMUX = 16,
	parameter SELW = 7
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NPINS-1:0] gpio_in,
	input wire [NLINES-1:NMUX] line_in,
	output wire [NLINES-1:0] irq_req,
	output reg [NLINES-1:0] evt_req,
	output wire irq
);
	// ==========================================================================
	// helpers
	function addr_ok;
		input [11:0] a;
		begin
			addr_ok = (a[1:0] == 2'h0) && (a <= `EELC_OFF_SMASK);
		end
	endfunction

	function pick_pin;
		input [NPINS-1:0] pins;
		input [SELW-1:0] idx;
		integer k;
		begin
			pick_pin = 1'h0;
			for (k = 0; k < NPINS; k = k + 1) begin
				if (idx == k[SELW-1:0])
					pick_pin = pins[k];
			end
		end
	endfunction

	function [NLINES-1:0] lines_of;
		input [31:0] d;
		begin
			lines_of = d[NLINES-1:0];
		end
	endfunction

	function sel_hit;
		input [11:0] a;
		input integer n;
		begin
			sel_hit = ((a - `EELC_OFF_SEL0) >> 2) == (n / `EELC_SEL_PER_REG);
		end
	endfunction

	function integer sel_pos;
		input integer n;
		begin
			sel_pos = (n % `EELC_SEL_PER_REG) * `EELC_SEL_FIELD;
		end
	endfunction

	// ==========================================================================
	// registers
	reg [NLINES-1:0] imask;
	reg [NLINES-1:0] emask;
	reg [NLINES-1:0] rise_en;
	reg [NLINES-1:0] fall_en;
	reg [NLINES-1:0] pend;
	reg [SELW-1:0] sel [0:NMUX-1];
	reg [1:0] stat;
	reg [1:0] smask;
	reg [1:0] stat_shown;

	// ==========================================================================
	// bus decode
	wire acc = psel & penable;
	wire setup = psel & ~penable;
	wire rd_setup = setup & ~pwrite;
	wire wr = acc & pwrite & addr_ok(paddr);
	wire rd = acc & ~pwrite & addr_ok(paddr);

	assign pready = 1'h1;
	assign pslverr = acc & ~addr_ok(paddr);

	// ==========================================================================
	// line sources and edge catchers
	wire [NLINES-1:0] line_src;
	wire [NLINES-1:0] rise_evt;
	wire [NLINES-1:0] fall_evt;

	genvar g;
	generate
		for (g = 0; g < NLINES; g = g + 1) begin : g_line
			if (g < NMUX) begin : g_mux
				assign line_src[g] = pick_pin(gpio_in, sel[g]); // R6
			end else begin : g_dir
				assign line_src[g] = line_in[g];
			end
			eelc_edge_catch u_catch (
				.pclk(pclk),
				.presetn(presetn),
				.line(line_src[g]),
				.rise_evt(rise_evt[g]),
				.fall_evt(fall_evt[g])
			); // R1
		end
	endgenerate

	// ==========================================================================
	// trigger, pending and status
	wire wr_sw = wr && (paddr == `EELC_OFF_SWTRIG);
	wire wr_pend = wr && (paddr == `EELC_OFF_PEND);
	wire [NLINES-1:0] sw_trig = wr_sw ? lines_of(pwdata) : {NLINES{1'h0}};
	wire [NLINES-1:0] pend_clr = wr_pend ? lines_of(pwdata) : {NLINES{1'h0}};
	wire [NLINES-1:0] trig = (rise_evt & rise_en) | (fall_evt & fall_en) | sw_trig; // R2
	wire [NLINES-1:0] trig_int = trig & imask; // R3
	wire [NLINES-1:0] next_pend = (pend & ~pend_clr) | trig_int; // R7
	wire [NLINES-1:0] next_evt = trig & emask; // R3

	// ==========================================================================
	// status, cleared by reading the bits shown
	wire ev_new = |(trig_int & ~pend);
	wire ev_ovr = |(trig_int & pend & ~pend_clr);
	wire rd_stat = rd && (paddr == `EELC_OFF_STAT);
	wire [1:0] stat_clr = rd_stat ? stat_shown : 2'h0;
	wire [1:0] ev_stat = {ev_ovr, ev_new};
	wire [1:0] next_stat = (stat & ~stat_clr) | ev_stat;

	assign irq_req = pend & imask; // R7
	assign irq = |(stat & smask);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= `EELC_RST_LINES;
			evt_req <= `EELC_RST_LINES;
			stat <= `EELC_RST_STAT;
		end else begin
			pend <= next_pend; // R4
			evt_req <= next_evt; // R3
			stat <= next_stat;
		end
	end

	// ==========================================================================
	// register writes
	integer i;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask <= `EELC_RST_LINES;
			emask <= `EELC_RST_LINES;
			rise_en <= `EELC_RST_LINES;
			fall_en <= `EELC_RST_LINES;
			smask <= `EELC_RST_STAT;
			for (i = 0; i < NMUX; i = i + 1)
				sel[i] <= `EELC_RST_SEL;
		end else if (wr) begin
			case (paddr)
				`EELC_OFF_IMASK: imask <= lines_of(pwdata); // R3
				`EELC_OFF_EMASK: emask <= lines_of(pwdata); // R3
				`EELC_OFF_RISE: rise_en <= lines_of(pwdata); // R2
				`EELC_OFF_FALL: fall_en <= lines_of(pwdata); // R2
				`EELC_OFF_SMASK: smask <= pwdata[1:0];
				`EELC_OFF_SEL0, `EELC_OFF_SEL1, `EELC_OFF_SEL2, `EELC_OFF_SEL3: begin
					for (i = 0; i < NMUX; i = i + 1) begin
						if (sel_hit(paddr, i))
							sel[i] <= pwdata[sel_pos(i) +: SELW]; // R6
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================================
	// read data, latched in the setup cycle
	reg [31:0] rd_val;
	integer j;
	always @* begin
		rd_val = 32'h00000000;
		j = 0;
		case (paddr)
			`EELC_OFF_IMASK: rd_val[NLINES-1:0] = imask;
			`EELC_OFF_EMASK: rd_val[NLINES-1:0] = emask;
			`EELC_OFF_RISE: rd_val[NLINES-1:0] = rise_en;
			`EELC_OFF_FALL: rd_val[NLINES-1:0] = fall_en;
			`EELC_OFF_PEND: rd_val[NLINES-1:0] = pend; // R4
			`EELC_OFF_SEL0, `EELC_OFF_SEL1, `EELC_OFF_SEL2, `EELC_OFF_SEL3: begin
				for (j = 0; j < NMUX; j = j + 1) begin
					if (sel_hit(paddr, j))
						rd_val[sel_pos(j) +: SELW] = sel[j];
				end
			end
			`EELC_OFF_STAT: rd_val[1:0] = stat;
			`EELC_OFF_SMASK: rd_val[1:0] = smask;
			default: rd_val = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			stat_shown <= 2'h0;
		end else if (rd_setup) begin
			prdata <= rd_val;
			stat_shown <= rd_val[1:0];
		end
	end
endmodule // eelc_top

// *** tb/eelc_checker.sv ***
// port assertions for the edge event line controller
`timescale 1ns/1ps
module eelc_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [22:0] irq_req,
	input wire [22:0] evt_req,
	input wire irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ====
	// bus side
	ready_high_a: assert property (pready)
		else $error("pready low");
	err_decode_a: assert property (pslverr == (psel && penable &&
		(paddr > 12'h02c || paddr[1:0] != 2'h0))) else $error("bad pslverr");
	rdata_stand_a: assert property (!(psel && !penable && !pwrite) |=>
		$stable(prdata)) else $error("prdata moved");
	// ====
	// pending and requests
	pend_hold_a: assert property (|(~irq_req & $past(irq_req)) |->
		$past(psel && penable && pwrite && (paddr == 12'h014 || paddr == 12'h000)))
		else $error("request dropped alone");
	pend_clear_a: assert property (psel && penable && pwrite && paddr == 12'h014 |=>
		!(|(irq_req & $past(pwdata[22:0])))) else $error("pending not cleared");
	irq_drop_a: assert property ($fell(irq) |->
		$past(psel && penable && (paddr == 12'h028 || paddr == 12'h02c)))
		else $error("irq dropped alone");
	evt_pulse_a: assert property (!(|(evt_req & $past(evt_req))))
		else $error("event longer than a cycle");
endmodule // eelc_checker

// *** tb/eelc_pins.sv ***
// pin side model: drives the gpio pins and direct lines
`timescale 1ns/1ps
module eelc_pins (
	output wire [80:0] gpio_in,
	output wire [22:16] line_in
);
	reg [87:0] src = 88'h0;
	assign gpio_in = src[80:0];
	assign line_in = src[87:81];
	// ====
	// pulse one source, index 81 up are direct lines
	task pulse(input int s, input int w);
		begin
			// start off the clock edge
			#1;
			src[s] = 1'h1;
			#(w);
			src[s] = 1'h0;
		end
	endtask
endmodule // eelc_pins

// *** tb/tb.sv ***
// self-checking bench for the edge event line controller
`timescale 1ns/1ps
module tb;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire irq;
	wire [80:0] gpio_in;
	wire [22:16] line_in;
	wire [22:0] irq_req;
	wire [22:0] evt_req;
	int n_errors = 0;
	int check_count = 0;
	always #2.5 pclk = ~pclk;
	eelc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpio_in(gpio_in), .line_in(line_in), .irq_req(irq_req),
		.evt_req(evt_req), .irq(irq));
	eelc_pins pins_u (.gpio_in(gpio_in), .line_in(line_in));
	// ====
	// checking and bus tasks
	task end_of_test;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// read compares against d
	task xfer(input w, input [11:0] a, input [31:0] d);
		int n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1) begin
				n++;
				if (n > 16) begin
					n_errors++;
					end_of_test;
				end
				@(posedge pclk);
			end
			chk({31'h0, pslverr}, {31'h0, (a > 12'h02c) || (a[1:0] != 2'h0)});
			if (!w) chk(prdata, d);
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// ====
	// scenarios
	task t_regs;
		for (int i = 0; i < 12; i++) xfer(1'b0, 12'(4 * i), 32'h0);
		xfer(1'b0, 12'h030, 32'h0);
	endtask
	// event observer, cleared by the scenarios
	reg [22:0] evt_seen = 23'h0;
	reg evt_clr = 1'h0;
	always @(posedge pclk) evt_seen <= evt_clr ? 23'h0 : (evt_seen | evt_req);
	task clr_evt;
		evt_clr <= 1'h1;
		@(posedge pclk);
		evt_clr <= 1'h0;
	endtask
	task t_status;
		xfer(1'b1, 12'h000, 32'h1);
		xfer(1'b1, 12'h02c, 32'h1);
		xfer(1'b1, 12'h010, 32'h1);
		#1 chk({31'h0, irq}, 32'h1);
		xfer(1'b0, 12'h014, 32'h1);
		xfer(1'b0, 12'h028, 32'h1);
		#1 chk({31'h0, irq}, 32'h0);
		xfer(1'b1, 12'h014, 32'h1);
		#1 chk({9'h0, irq_req}, 32'h0);
	endtask
	task t_edges;
		xfer(1'b1, 12'h000, 32'h7fffff);
		xfer(1'b1, 12'h004, 32'h7fffff);
		xfer(1'b1, 12'h018, 32'h0550);
		xfer(1'b1, 12'h008, 32'h400001);
		xfer(1'b1, 12'h00c, 32'h400002);
		clr_evt;
		pins_u.pulse(80, 1);
		pins_u.pulse(5, 20);
		pins_u.pulse(87, 20);
		repeat (6) @(posedge pclk);
		xfer(1'b0, 12'h014, 32'h400003);
		#1 chk({9'h0, irq_req}, 32'h400003);
		chk({9'h0, evt_seen}, 32'h400003);
	endtask
	task t_mask;
		xfer(1'b1, 12'h014, 32'h7fffff);
		xfer(1'b1, 12'h000, 32'h2);
		xfer(1'b1, 12'h004, 32'h1);
		clr_evt;
		pins_u.pulse(80, 1);
		pins_u.pulse(5, 20);
		repeat (6) @(posedge pclk);
		xfer(1'b0, 12'h014, 32'h2);
		#1 chk({9'h0, irq_req}, 32'h2);
		chk({9'h0, evt_seen}, 32'h1);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_status;
		t_edges;
		t_mask;
		end_of_test;
	end
endmodule // tb
bind eelc_top eelc_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_req(irq_req), .evt_req(evt_req), .irq(irq));
